// *** hdl/ext_osc_pkg.sv ***
// Overview of operation
// - bit 7 reads one when oscillator stable in modes 1xx
// - valid flag reads zero in CMOS modes
// - mode codes 00x disable the oscillator
// - 010 CMOS input, 011 CMOS divided
// - 100 RC oscillator, 101 capacitor oscillator
// - 110 crystal, 111 crystal divided by two
// - bit 3 reserved, reads zero, write zero
// - bits 2:0 bias current, all codes passed
package ext_osc_pkg;
    localparam logic [7:0] EXT_OSC_CONTROL_ADDR = 8'hb1;
    localparam logic [7:0] EXT_OSC_CONTROL_RESET = 8'h00;
    localparam int VALID_BIT = 7;
    localparam int MODE_MSB = 6;
    localparam int MODE_LSB = 4;
    localparam int RSVD_BIT = 3;
    localparam int BIAS_MSB = 2;
    localparam int BIAS_LSB = 0;
    localparam logic [2:0] MODE_CMOS = 3'h2;
    localparam logic [2:0] MODE_CMOS_DIV2 = 3'h3;
    localparam logic [2:0] MODE_RC = 3'h4;
    localparam logic [2:0] MODE_CAP = 3'h5;
    localparam logic [2:0] MODE_XTAL = 3'h6;
    localparam logic [2:0] MODE_XTAL_DIV2 = 3'h7;
    typedef enum logic [2:0] {
        OSC_OFF,
        OSC_CMOS,
        OSC_RC,
        OSC_CAP,
        OSC_XTAL
    } osc_kind_t;
endpackage

// *** hdl/external_oscillator_control.sv ***
`timescale 1ns/1ps
module external_oscillator_control (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrWe,
    input wire logic sfrRe,
    output logic [7:0] sfrRdata,
    input wire logic oscStable,
    input wire logic oscIn,
    output logic oscEnable,
    output ext_osc_pkg::osc_kind_t oscKind,
    output logic [2:0] ext_osc_bias_ctrl,
    output logic oscClkOut
);
    import ext_osc_pkg::*;

    logic [2:0] ext_osc_mode_sel;
    logic [2:0] stableSync;
    logic [2:0] inSync;
    logic stableSeen;
    logic inSeen;
    logic ext_clock_valid;
    logic divHalf;
    logic divMode;
    logic inRise;
    osc_kind_t next_oscKind;

    // register writes; reserved bit 3 and bit 7 not stored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_osc_mode_sel <= EXT_OSC_CONTROL_RESET[MODE_MSB:MODE_LSB];
            ext_osc_bias_ctrl <= EXT_OSC_CONTROL_RESET[BIAS_MSB:BIAS_LSB];
        end else if (sfrWe && sfrAddr == EXT_OSC_CONTROL_ADDR) begin
            ext_osc_mode_sel <= sfrWdata[MODE_MSB:MODE_LSB];
            ext_osc_bias_ctrl <= sfrWdata[BIAS_MSB:BIAS_LSB];
        end
    end

    // three-stage synchronisers for pin inputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stableSync <= 3'h0;
            inSync <= 3'h0;
            stableSeen <= 1'b0;
            inSeen <= 1'b0;
        end else begin
            stableSync <= {stableSync[1:0], oscStable};
            inSync <= {inSync[1:0], oscIn};
            if (stableSync[1] == stableSync[2]) begin
                stableSeen <= stableSync[2];
            end
            if (inSync[1] == inSync[2]) begin
                inSeen <= inSync[2];
            end
        end
    end

    // mode decode
    always_comb begin
        case (ext_osc_mode_sel)
            MODE_CMOS, MODE_CMOS_DIV2: next_oscKind = OSC_CMOS;
            MODE_RC: next_oscKind = OSC_RC;
            MODE_CAP: next_oscKind = OSC_CAP;
            MODE_XTAL, MODE_XTAL_DIV2: next_oscKind = OSC_XTAL;
            default: next_oscKind = OSC_OFF;
        endcase
    end

    assign divMode = (ext_osc_mode_sel == MODE_CMOS_DIV2) || (ext_osc_mode_sel == MODE_XTAL_DIV2);
    assign inRise = (inSync[1] == inSync[2]) && inSync[2] && !inSeen;
    // valid only in non-CMOS running modes
    assign ext_clock_valid = stableSeen && (next_oscKind != OSC_OFF)
        && (next_oscKind != OSC_CMOS);

    // analogue controls and divided clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oscKind <= OSC_OFF;
            oscEnable <= 1'b0;
            divHalf <= 1'b0;
            oscClkOut <= 1'b0;
        end else begin
            oscKind <= next_oscKind;
            oscEnable <= (next_oscKind != OSC_OFF);
            if (next_oscKind == OSC_OFF) begin
                divHalf <= 1'b0;
            end else if (inRise) begin
                divHalf <= !divHalf;
            end
            oscClkOut <= divMode ? divHalf : inSeen;
        end
    end

    // read data; reserved bit reads zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sfrRdata <= 8'h00;
        end else if (sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR) begin
            sfrRdata <= {ext_clock_valid, ext_osc_mode_sel, 1'b0, ext_osc_bias_ctrl};
        end else begin
            sfrRdata <= 8'h00;
        end
    end

    // read side: valid flag, reserved bit, idle level and field readback

    // valid flag never set in either cmos mode
    AST_CMOS_NOT_VALID: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR && next_oscKind == OSC_CMOS)
        |=> !sfrRdata[VALID_BIT]) else $error("valid flag set in cmos mode");

    // reserved bit never reads as one
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        !sfrRdata[RSVD_BIT])
        else $error("reserved bit read as one");

    // valid flag low while the stable pin is not seen
    AST_VALID_STABLE: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR && !stableSeen) |=> !sfrRdata[VALID_BIT])
        else $error("valid without stable");

    // valid flag high when stable in rc, capacitor or crystal mode
    AST_VALID_SET: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR && stableSeen && ext_osc_mode_sel[2])
        |=> sfrRdata[VALID_BIT]) else $error("valid flag missing");

    // read data is zero outside a register read
    AST_IDLE_READ: assert property (@(posedge clk) disable iff (!rst_b)
        !(sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR) |=> sfrRdata == 8'h00)
        else $error("read data not idle");

    // bias field reads back what is held
    AST_BIAS_READ: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR) |=> sfrRdata[2:0] == $past(ext_osc_bias_ctrl))
        else $error("bias readback wrong");

    // mode field reads back what is held
    AST_MODE_READ: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR)
        |=> sfrRdata[MODE_MSB:MODE_LSB] == $past(ext_osc_mode_sel)) else $error("mode readback wrong");

    // write side: fields land, other addresses leave them alone

    // bias field takes the written code
    AST_WRITE_BIAS: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrWe && sfrAddr == EXT_OSC_CONTROL_ADDR) |=> ext_osc_bias_ctrl == $past(sfrWdata[2:0]))
        else $error("bias not written");

    // mode field takes the written code
    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrWe && sfrAddr == EXT_OSC_CONTROL_ADDR)
        |=> ext_osc_mode_sel == $past(sfrWdata[MODE_MSB:MODE_LSB])) else $error("mode not written");

    // writes to other addresses change nothing
    AST_OTHER_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        (sfrWe && sfrAddr != EXT_OSC_CONTROL_ADDR)
        |=> $stable(ext_osc_bias_ctrl) && $stable(ext_osc_mode_sel)) else $error("stray write");

    // mode decode onto the analogue controls

    // 00x turns the circuit off
    AST_DISABLE: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel[2:1] == 2'b00) |=> !oscEnable)
        else $error("osc not disabled");

    // any other mode turns it on
    AST_ENABLE_ON: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel[2:1] != 2'b00) |=> oscEnable)
        else $error("osc not enabled");

    // 00x decodes to off
    AST_OFF_KIND: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel[2:1] == 2'b00) |=> oscKind == OSC_OFF)
        else $error("off decode");

    // plain cmos input
    AST_CMOS_PLAIN_KIND: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel == MODE_CMOS) |=> oscKind == OSC_CMOS)
        else $error("cmos plain decode");

    // cmos input with the divide stage
    AST_CMOS_KIND: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel == MODE_CMOS_DIV2) |=> oscKind == OSC_CMOS)
        else $error("cmos decode");

    // rc oscillator
    AST_RC_KIND: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel == MODE_RC) |=> oscKind == OSC_RC)
        else $error("rc decode");

    // capacitor oscillator
    AST_CAP_KIND: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel == MODE_CAP) |=> oscKind == OSC_CAP)
        else $error("capacitor decode");

    // crystal, with or without the divide stage
    AST_XTAL_KIND: assert property (@(posedge clk) disable iff (!rst_b)
        (ext_osc_mode_sel[2:1] == 2'b11) |=> oscKind == OSC_XTAL)
        else $error("xtal decode");

    // pin filtering and the divided clock

    // stable pin only counts once two stages agree
    AST_STABLE_FILTER: assert property (@(posedge clk) disable iff (!rst_b)
        (stableSync[2] != stableSync[1]) |=> stableSeen == $past(stableSeen))
        else $error("stable pin glitch passed");

    // oscillator pin only counts once two stages agree
    AST_IN_FILTER: assert property (@(posedge clk) disable iff (!rst_b)
        (inSync[2] != inSync[1]) |=> inSeen == $past(inSeen))
        else $error("oscillator pin glitch passed");

    // divider flips on every accepted rising edge while the circuit is on
    AST_DIV_TOGGLE: assert property (@(posedge clk) disable iff (!rst_b)
        (inRise && next_oscKind != OSC_OFF) |=> divHalf != $past(divHalf))
        else $error("divider missed edge");

    // divider holds between rising edges
    AST_DIV_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        (!inRise && next_oscKind != OSC_OFF) |=> divHalf == $past(divHalf))
        else $error("divider moved without edge");

    // divider parked low while the circuit is off
    AST_DIV_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        (next_oscKind == OSC_OFF) |=> !divHalf)
        else $error("divider not parked");

    // halved clock goes onward in the divide modes
    AST_DIV_OUT: assert property (@(posedge clk) disable iff (!rst_b)
        divMode |=> oscClkOut == $past(divHalf))
        else $error("divided clock not passed");

    // filtered pin goes onward otherwise
    AST_PASS_OUT: assert property (@(posedge clk) disable iff (!rst_b)
        !divMode |=> oscClkOut == $past(inSeen))
        else $error("undivided clock not passed");

    // main scenarios to be reached
    COV_VALID_READ: cover property (@(posedge clk) disable iff (!rst_b)
        sfrRe && sfrAddr == EXT_OSC_CONTROL_ADDR && ext_clock_valid);
    COV_DIV_XTAL: cover property (@(posedge clk) disable iff (!rst_b)
        ext_osc_mode_sel == MODE_XTAL_DIV2 && inRise);
    COV_CMOS: cover property (@(posedge clk) disable iff (!rst_b)
        next_oscKind == OSC_CMOS && stableSeen);
    COV_DIV_CMOS: cover property (@(posedge clk) disable iff (!rst_b)
        ext_osc_mode_sel == MODE_CMOS_DIV2 && inRise);
    COV_CAP_STABLE: cover property (@(posedge clk) disable iff (!rst_b)
        oscKind == OSC_CAP && stableSeen);
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import ext_osc_pkg::*;
    logic clk, rst_b, sfrWe, sfrRe, oscStable, oscIn, oscEnable, oscClkOut, taken, last, cnt;
    logic [7:0] sfrAddr, sfrWdata, sfrRdata;
    logic [2:0] ext_osc_bias_ctrl, bias;
    logic [31:0] seed = 32'h4c63;
    logic [31:0] rnd;
    osc_kind_t oscKind;
    logic [7:0] expQ[$];
    int n_mismatch = 0, check_count = 0, toggles = 0, e;
    external_oscillator_control u_dut (.clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
        .sfrWdata(sfrWdata), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrRdata(sfrRdata),
        .oscStable(oscStable), .oscIn(oscIn), .oscEnable(oscEnable), .oscKind(oscKind),
        .ext_osc_bias_ctrl(ext_osc_bias_ctrl), .oscClkOut(oscClkOut));
    // xorshift source for bias and stable pin
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic osc_kind_t kindOf(input logic [2:0] m);
        case (m)
            3'h2, 3'h3: return OSC_CMOS;
            3'h4: return OSC_RC;
            3'h5: return OSC_CAP;
            3'h6, 3'h7: return OSC_XTAL;
            default: return OSC_OFF;
        endcase
    endfunction
    // one compare per kind of result: register read data and output levels
    task automatic cmpRead(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t read got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpLevel(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t level got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // one register bus cycle, expected read data noted in the queue
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 sfrAddr = a;
        sfrWdata = d;
        sfrWe = w;
        sfrRe = !w;
        if (!w) expQ.push_back(d);
        @(posedge clk);
        #1 sfrWe = 0;
        sfrRe = 0;
    endtask
    // clock, slow oscillator pin, read monitor and edge counter
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    initial begin
        oscIn = 0;
        forever begin
            repeat (8) @(posedge clk);
            #1 oscIn = ~oscIn;
        end
    end
    always @(posedge clk) taken <= sfrRe;
    always @(negedge clk) begin
        if (taken) cmpRead(sfrRdata, expQ.pop_front());
    end
    // toggle counter samples the onward clock away from its launching edge
    always @(negedge clk) begin
        if (cnt && oscClkOut !== last) toggles++;
        last = oscClkOut;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        rst_b = 0; sfrAddr = 0; sfrWdata = 0; sfrWe = 0; sfrRe = 0; oscStable = 0; cnt = 0;
        repeat (3) @(posedge clk);
        #1 rst_b = 1;
        acc(0, 8'hb1, 8'h00);
        for (int m = 0; m < 8; m++) begin
            rnd = xs();
            {oscStable, bias} = rnd[3:0];
            acc(1, 8'hb1, {1'b1, m[2:0], 1'b0, bias});
            acc(1, 8'hb0, 8'h00);
            repeat (8) @(posedge clk);
            #1;
            cmpLevel({5'h0, oscKind}, {5'h0, kindOf(m[2:0])});
            cmpLevel({7'h0, oscEnable}, {7'h0, |m[2:1]});
            cmpLevel({5'h0, ext_osc_bias_ctrl}, {5'h0, bias});
            acc(0, 8'hb1, {oscStable & m[2], m[2:0], 1'b0, bias});
            acc(0, 8'hb2, 8'h00);
            $display("mode %0d test done", m);
        end
        for (int m = 2; m < 8; m++) begin
            acc(1, 8'hb1, {1'b0, m[2:0], 4'h0});
            repeat (10) @(posedge clk);
            toggles = 0;
            cnt = 1;
            repeat (160) @(posedge clk);
            cnt = 0;
            e = (m[2:0] == MODE_CMOS_DIV2 || m[2:0] == MODE_XTAL_DIV2) ? 10 : 20;
            cmpLevel(8'(toggles >= e - 1 && toggles <= e + 1), 8'h01);
            $display("divider test %0d done", m);
        end
        tally_and_finish();
    end
endmodule
